// ===== hdl/spims_shifter.sv
// spi master/slave port: serial shifter, master clock generator and slave engine
// assumes pin inputs arrive already synchronised to clock
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spims_defines.svh"
module spims_shifter #(
  parameter int WIDTH = 8
) (
  input  wire logic   clock,
  input  wire logic   rst,
  spims_ctl_if.shift  ctl,
  input  wire logic   sclkIn,
  input  wire logic   csInN,
  input  wire logic   misoIn,
  input  wire logic   mosiIn,
  output logic        sclkOut,
  output logic        sclkOe,
  output logic        csOutN,
  output logic        misoOut,
  output logic        misoOe,
  output logic        mosiOut
);
  localparam int CW = $clog2(WIDTH + 1);

  spims_pkg::spims_state_t stateQ, stateD;
  logic [7:0]       cntQ, cntD;
  logic [CW-1:0]    bitQ, bitD;
  logic [WIDTH-1:0] shQ, shD;
  logic             phaseQ, phaseD;
  logic             sclkQ, sclkD;
  logic             csQ, csD;
  logic             doutQ, doutD;
  logic             sclkPrevQ;
  logic [WIDTH-1:0] rxD;
  logic             rxStbD, takenD;
  logic             sRise, sFall, sLead, sTrail;

  // slave edges come from the sampled partner clock; cpol picks leading edge
  assign sRise  = sclkIn & ~sclkPrevQ;
  assign sFall  = ~sclkIn & sclkPrevQ;
  assign sLead  = ctl.cpol ? sFall : sRise;
  assign sTrail = ctl.cpol ? sRise : sFall;

  always_comb begin
    stateD = stateQ;
    cntD   = cntQ;
    bitD   = bitQ;
    shD    = shQ;
    phaseD = phaseQ;
    sclkD  = sclkQ;
    csD    = csQ;
    doutD  = doutQ;
    rxD    = ctl.rxData;
    rxStbD = 1'b0;
    takenD = 1'b0;
    unique case (stateQ)
      spims_pkg::SPIMS_IDLE: begin
        sclkD = ctl.cpol;
        csD   = 1'b1;
        if (ctl.enable && !ctl.master) begin
          stateD = spims_pkg::SPIMS_SLAVE;
          shD    = ctl.txValid ? ctl.txData : '0;
          takenD = ctl.txValid;
          bitD   = CW'(WIDTH);
          doutD  = ctl.txValid ? ctl.txData[WIDTH-1] : 1'b0;
        end else if (ctl.enable && ctl.txValid) begin
          stateD = spims_pkg::SPIMS_CSDLY;
          csD    = 1'b0;
          cntD   = ctl.csDelay;
        end
      end
      spims_pkg::SPIMS_CSDLY: begin
        // chip select stands low this many clocks (at least one) before the first-word delay starts
        if (cntQ <= 8'h01) begin
          stateD = spims_pkg::SPIMS_FWDLY;
          cntD   = ctl.firstDelay;
        end else
          cntD = cntQ - 8'h01;
      end
      spims_pkg::SPIMS_FWDLY: begin
        if (cntQ == 8'h00) begin
          stateD = spims_pkg::SPIMS_SHIFT;
          shD    = ctl.txData;
          takenD = 1'b1;
          bitD   = CW'(WIDTH);
          phaseD = 1'b0;
          doutD  = ctl.txData[WIDTH-1];
          cntD   = ctl.clkDiv;
        end else
          cntD = cntQ - 8'h01;
      end
      spims_pkg::SPIMS_SHIFT: begin
        if (cntQ <= 8'h01) begin
          cntD   = ctl.clkDiv;
          phaseD = ~phaseQ;
          sclkD  = ~sclkQ;
          if (phaseQ == ctl.cpha) begin
            shD = {shQ[WIDTH-2:0], misoIn};
          end else if (ctl.cpha) begin
            doutD = shQ[WIDTH-1];
          end
          if (phaseQ) begin
            bitD = bitQ - CW'(1);
            if (!ctl.cpha) doutD = shQ[WIDTH-1];
            if (bitQ == CW'(1)) begin
              // with cpha set the last bit is sampled on this very edge
              rxD    = ctl.cpha ? {shQ[WIDTH-2:0], misoIn} : shQ;
              rxStbD = 1'b1;
              if (ctl.txValid && ctl.enable) begin
                shD    = ctl.txData;
                takenD = 1'b1;
                bitD   = CW'(WIDTH);
                doutD  = ctl.txData[WIDTH-1];
              end else begin
                stateD = spims_pkg::SPIMS_IDLE;
                csD    = 1'b1;
              end
            end
          end
        end else
          cntD = cntQ - 8'h01;
      end
      spims_pkg::SPIMS_SLAVE: begin
        if (!ctl.enable || ctl.master) stateD = spims_pkg::SPIMS_IDLE;
        else if (csInN) begin
          // deselect restarts the word frame
          bitD = CW'(WIDTH);
          // a word written while deselected loads at once; txTaken stops a double take
          if (ctl.txValid && !ctl.txTaken) begin
            shD    = ctl.txData;
            takenD = 1'b1;
          end
          doutD = shD[WIDTH-1];
        end else begin
          if ((sLead && !ctl.cpha) || (sTrail && ctl.cpha)) begin
            shD  = {shQ[WIDTH-2:0], mosiIn};
            bitD = bitQ - CW'(1);
            if (bitQ == CW'(1)) begin
              // next word loads on the same edge: no dead cycle
              rxD    = {shQ[WIDTH-2:0], mosiIn};
              rxStbD = 1'b1;
              bitD   = CW'(WIDTH);
              shD    = ctl.txValid ? ctl.txData : '0;
              takenD = ctl.txValid;
            end
          end
          if ((sTrail && !ctl.cpha) || (sLead && ctl.cpha && bitQ != CW'(WIDTH)))
            doutD = shQ[WIDTH-1];
          if (sTrail && !ctl.cpha && bitQ == CW'(WIDTH)) doutD = shQ[WIDTH-1];
        end
      end
      default: stateD = spims_pkg::SPIMS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stateQ       <= spims_pkg::SPIMS_IDLE;
      cntQ         <= 8'h00;
      bitQ         <= '0;
      shQ          <= '0;
      phaseQ       <= 1'b0;
      sclkQ        <= 1'b0;
      csQ          <= 1'b1;
      doutQ        <= 1'b0;
      sclkPrevQ    <= 1'b0;
      ctl.rxData   <= '0;
      ctl.rxStrobe <= 1'b0;
      ctl.txTaken  <= 1'b0;
    end else begin
      stateQ       <= stateD;
      cntQ         <= cntD;
      bitQ         <= bitD;
      shQ          <= shD;
      phaseQ       <= phaseD;
      sclkQ        <= sclkD;
      csQ          <= csD;
      doutQ        <= doutD;
      sclkPrevQ    <= sclkIn;
      ctl.rxData   <= rxD;
      ctl.rxStrobe <= rxStbD;
      ctl.txTaken  <= takenD;
    end
  end

  assign ctl.busy = (stateQ != spims_pkg::SPIMS_IDLE) &&
                    !(stateQ == spims_pkg::SPIMS_SLAVE && csInN);
  assign sclkOut  = sclkQ;
  assign sclkOe   = ctl.enable & ctl.master;
  assign csOutN   = csQ;
  assign mosiOut  = doutQ;
  assign misoOut  = doutQ;
  assign misoOe   = (stateQ == spims_pkg::SPIMS_SLAVE) & ~csInN;
endmodule
`default_nettype wire

// ===== hdl/spims_defines.svh
// spi master/slave port: register offsets, field positions, reset values
// assumes inclusion by bare name from design files under hdl/
`ifndef SPIMS_DEFINES_SVH
`define SPIMS_DEFINES_SVH

`define SPIMS_OFF_CTRL     12'h000
`define SPIMS_OFF_TIMING   12'h004
`define SPIMS_OFF_TXDATA   12'h008
`define SPIMS_OFF_RXDATA   12'h00C
`define SPIMS_OFF_STATUS   12'h010

`define SPIMS_CTRL_EN      0
`define SPIMS_CTRL_MASTER  1
`define SPIMS_CTRL_CPOL    2
`define SPIMS_CTRL_CPHA    3
`define SPIMS_CTRL_DIV_LO  8
`define SPIMS_CTRL_DIV_HI  15

`define SPIMS_TIM_CSD_LO   0
`define SPIMS_TIM_CSD_HI   7
`define SPIMS_TIM_FWD_LO   8
`define SPIMS_TIM_FWD_HI   15

`define SPIMS_ST_BUSY      0
`define SPIMS_ST_TXEMPTY   1
`define SPIMS_ST_RXFULL    2
`define SPIMS_ST_OVERRUN   3

`define SPIMS_DIV_RESET    8'h01
`define SPIMS_CSD_RESET    8'h01
`define SPIMS_FWD_RESET    8'h00

`endif

// ===== hdl/spims_pkg.sv
// spi master/slave port: shared types
// assumes spims_defines.svh alongside
package spims_pkg;
  typedef enum logic [2:0] {
    SPIMS_IDLE  = 3'h0,
    SPIMS_CSDLY = 3'h1,
    SPIMS_FWDLY = 3'h3,
    SPIMS_SHIFT = 3'h2,
    SPIMS_SLAVE = 3'h6
  } spims_state_t;
endpackage

// ===== hdl/spims_ctl_if.sv
// spi master/slave port: bundle between register file and shifter
// assumes one clock domain, clock of the top module
`timescale 1ns/1ps
`default_nettype none
interface spims_ctl_if #(parameter int WIDTH = 8);
  logic             enable;
  logic             master;
  logic             cpol;
  logic             cpha;
  logic [7:0]       clkDiv;
  logic [7:0]       csDelay;
  logic [7:0]       firstDelay;
  logic [WIDTH-1:0] txData;
  logic             txValid;
  logic             txTaken;
  logic [WIDTH-1:0] rxData;
  logic             rxStrobe;
  logic             busy;
  modport regs  (output enable, master, cpol, cpha, clkDiv, csDelay, firstDelay, txData,
                 txValid, input txTaken, rxData, rxStrobe, busy);
  modport shift (input enable, master, cpol, cpha, clkDiv, csDelay, firstDelay, txData,
                 txValid, output txTaken, rxData, rxStrobe, busy);
endinterface
`default_nettype wire

// ===== hdl/spims_top.sv
// spi master/slave port: apb register file, pin synchronisers, shifter
// assumes apb master on clock; pins come from outside and are synchronised here
// Operation
// - one unit, software selects master or slave
// - programmable clock rate, polarity and phase
// - master: programmable select-to-clock interval
// - master: programmable delay before first word
// - slave takes in words back to back; it sends them back to back intact with cpha clear only
`timescale 1ns/1ps
`default_nettype none
`include "spims_defines.svh"
module spims_top #(
  parameter int WIDTH = 8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  output logic             sclkOe,
  input  wire logic        csInN,
  output logic             csOutN,
  output logic             mosiOut,
  input  wire logic        mosiIn,
  output logic             misoOut,
  output logic             misoOe,
  input  wire logic        misoIn
);
  spims_ctl_if #(.WIDTH(WIDTH)) ctl ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: second stage only is read
  logic [3:0] syncAQ, syncBQ;
  always_ff @(posedge clock) begin
    if (rst) begin
      syncAQ <= 4'hF;
      syncBQ <= 4'hF;
    end else begin
      syncAQ <= {sclkIn, csInN, mosiIn, misoIn};
      syncBQ <= syncAQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic             enQ, enD, msQ, msD, cpolQ, cpolD, cphaQ, cphaD;
  logic [7:0]       divQ, divD, csdQ, csdD, fwdQ, fwdD;
  logic [WIDTH-1:0] txQ, txD, rxQ, rxD;
  logic             txvQ, txvD, rxfQ, rxfD, ovrQ, ovrD;
  logic [31:0]      rdataD;
  logic             wrAcc, rdAcc, hit;

  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & penable & ~pwrite;

  always_comb begin
    enD = enQ; msD = msQ; cpolD = cpolQ; cphaD = cphaQ;
    divD = divQ; csdD = csdQ; fwdD = fwdQ; txD = txQ;
    txvD = txvQ & ~ctl.txTaken;
    rxD  = rxQ;
    rxfD = rxfQ;
    ovrD = ovrQ;
    hit  = 1'b1;
    rdataD = 32'h0000_0000;
    unique case (paddr)
      `SPIMS_OFF_CTRL: begin
        rdataD[`SPIMS_CTRL_EN]     = enQ;
        rdataD[`SPIMS_CTRL_MASTER] = msQ;
        rdataD[`SPIMS_CTRL_CPOL]   = cpolQ;
        rdataD[`SPIMS_CTRL_CPHA]   = cphaQ;
        rdataD[`SPIMS_CTRL_DIV_HI:`SPIMS_CTRL_DIV_LO] = divQ;
        if (wrAcc) begin
          enD   = pwdata[`SPIMS_CTRL_EN];
          msD   = pwdata[`SPIMS_CTRL_MASTER];
          cpolD = pwdata[`SPIMS_CTRL_CPOL];
          cphaD = pwdata[`SPIMS_CTRL_CPHA];
          // a zero divider is stored as the reset divider of one
          divD  = (pwdata[`SPIMS_CTRL_DIV_HI:`SPIMS_CTRL_DIV_LO] == 8'h00) ?
                  `SPIMS_DIV_RESET : pwdata[`SPIMS_CTRL_DIV_HI:`SPIMS_CTRL_DIV_LO];
        end
      end
      `SPIMS_OFF_TIMING: begin
        rdataD[`SPIMS_TIM_CSD_HI:`SPIMS_TIM_CSD_LO] = csdQ;
        rdataD[`SPIMS_TIM_FWD_HI:`SPIMS_TIM_FWD_LO] = fwdQ;
        if (wrAcc) begin
          csdD = pwdata[`SPIMS_TIM_CSD_HI:`SPIMS_TIM_CSD_LO];
          fwdD = pwdata[`SPIMS_TIM_FWD_HI:`SPIMS_TIM_FWD_LO];
        end
      end
      `SPIMS_OFF_TXDATA: begin
        rdataD[WIDTH-1:0] = txQ;
        if (wrAcc) begin
          txD  = pwdata[WIDTH-1:0];
          txvD = 1'b1;
        end
      end
      `SPIMS_OFF_RXDATA: begin
        rdataD[WIDTH-1:0] = rxQ;
        if (rdAcc) rxfD = 1'b0;
      end
      `SPIMS_OFF_STATUS: begin
        rdataD[`SPIMS_ST_BUSY]    = ctl.busy;
        rdataD[`SPIMS_ST_TXEMPTY] = ~txvQ;
        rdataD[`SPIMS_ST_RXFULL]  = rxfQ;
        rdataD[`SPIMS_ST_OVERRUN] = ovrQ;
        if (wrAcc && pwdata[`SPIMS_ST_OVERRUN]) ovrD = 1'b0;
      end
      default: hit = 1'b0;
    endcase
    // received word wins over a read clear in the same cycle
    if (ctl.rxStrobe) begin
      rxD  = ctl.rxData;
      ovrD = ovrD | rxfQ;
      rxfD = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      enQ <= 1'b0; msQ <= 1'b0; cpolQ <= 1'b0; cphaQ <= 1'b0;
      divQ <= `SPIMS_DIV_RESET;
      csdQ <= `SPIMS_CSD_RESET;
      fwdQ <= `SPIMS_FWD_RESET;
      txQ  <= '0; txvQ <= 1'b0; rxQ <= '0; rxfQ <= 1'b0; ovrQ <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      enQ <= enD; msQ <= msD; cpolQ <= cpolD; cphaQ <= cphaD;
      divQ <= divD; csdQ <= csdD; fwdQ <= fwdD;
      txQ <= txD; txvQ <= txvD; rxQ <= rxD; rxfQ <= rxfD; ovrQ <= ovrD;
      prdata  <= (psel & ~penable) ? rdataD : prdata;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  assign pready = 1'b1;

  assign ctl.enable     = enQ;
  assign ctl.master     = msQ;
  assign ctl.cpol       = cpolQ;
  assign ctl.cpha       = cphaQ;
  assign ctl.clkDiv     = divQ;
  assign ctl.csDelay    = csdQ;
  assign ctl.firstDelay = fwdQ;
  assign ctl.txData     = txQ;
  assign ctl.txValid    = txvQ;

  ////////////////////////////////////////////////////////////////////////////
  spims_shifter #(.WIDTH(WIDTH)) u_shift (
    .clock   (clock),
    .rst     (rst),
    .ctl     (ctl),
    .sclkIn  (syncBQ[3]),
    .csInN   (syncBQ[2]),
    .mosiIn  (syncBQ[1]),
    .misoIn  (syncBQ[0]),
    .sclkOut (sclkOut),
    .sclkOe  (sclkOe),
    .csOutN  (csOutN),
    .mosiOut (mosiOut),
    .misoOut (misoOut),
    .misoOe  (misoOe)
  );
endmodule
`default_nettype wire

// ===== tb/spims_assertions.sv
// spi port checker: pin relations of the register bus and both link modes
// assumes bind onto spims_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module spims_assertions #(
  parameter int WIDTH = 8
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclkOut,
  input wire logic        sclkOe,
  input wire logic        csOutN,
  input wire logic        csInN,
  input wire logic        misoOe
);
  int   togQ;
  int   togD;
  logic sclkPrevQ;

  ////////////////////////////////////////////////////////////////////////////
  // toggles of the master clock inside one select window
  always_comb togD = csOutN ? 0 : togQ + int'(sclkOut != sclkPrevQ);
  always_ff @(posedge clock) begin
    togQ      <= rst ? 0 : togD;
    sclkPrevQ <= sclkOut;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence quietClk;
    $stable(sclkOut) [*2];
  endsequence

  apb_ready_a: assert property (
    psel && penable |-> pready) else $error("access phase without ready");
  unmapped_err_a: assert property (
    psel && !penable && paddr > 12'h010 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    psel && !penable && paddr <= 12'h010 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  cs_lead_a: assert property (
    $fell(csOutN) |-> quietClk) else $error("clock moved as select fell");
  // chained words are legal, so only whole words are demanded
  frame_bits_a: assert property (
    $rose(csOutN) |-> (togQ + int'(sclkOut != sclkPrevQ)) % (2 * WIDTH) == 0
      && togQ + int'(sclkOut != sclkPrevQ) != 0) else $error("partial word in frame");
  master_pins_a: assert property (
    !csOutN |-> sclkOe) else $error("select driven without master clock");
  slave_quiet_a: assert property (
    misoOe |-> !sclkOe && csOutN) else $error("slave drives master pins");
  miso_oe_sync_a: assert property (
    misoOe |-> !$past(csInN, 2)) else $error("slave output not tied to select");
endmodule
`default_nettype wire

// ===== tb/spims_far_end.sv
// spi port bench: external slave answering the master pins
// assumes select, clock and data sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module spims_far_end #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             sclk,
  input  wire logic             csN,
  input  wire logic             cpha,
  input  wire logic             dIn,
  input  wire logic [WIDTH-1:0] reply,
  output logic                  dOut = 1'b0,
  output logic      [WIDTH-1:0] got = '0
);
  int   edges = 0;
  int   nxt;
  int   idx;
  logic sclkQ = 1'b0;
  logic csQ   = 1'b1;

  always @(posedge clock) begin
    sclkQ <= sclk;
    csQ   <= csN;
    nxt = edges + int'(sclk != sclkQ);
    idx = cpha ? (nxt == 0 ? 0 : (nxt - 1) / 2) : nxt / 2;
    // the last clock edge meets the rising select, so judge it by the old select
    if (!csQ && sclk != sclkQ && nxt % 2 == (cpha ? 0 : 1)) begin
      got <= {got[WIDTH-2:0], dIn};
    end
    if (csN) begin
      edges <= 0;
      dOut  <= ~dOut; // released line must not hold its last bit
    end else begin
      edges <= nxt;
      dOut <= (idx < WIDTH) ? reply[WIDTH-1-idx] : ~dOut;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// spi port bench: apb tasks, master frames in all four modes, one slave frame
// assumes spims_top on a 40 MHz clock, far-end slave on the master pins
`timescale 1ns/1ps
`default_nettype none
`include "spims_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sclkIn = 1'b0, csInN = 1'b1, mosiIn = 1'b0, cpha = 1'b0;
  logic        pready, pslverr, sclkOut, sclkOe, csOutN, mosiOut, misoOut, misoOe;
  logic        misoIn, err, prev;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  reply = 8'h0, got, tx;
  logic [15:0] sg;
  int          mismatches = 0, checks = 0, cyc = 0, n, tg, lat, eff, base;
  localparam logic [15:0] MOSI_WORD = 16'hC369;

  always #12.5 clock = ~clock;

  spims_top #(.WIDTH(8)) spims_top_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclkIn(sclkIn), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .csInN(csInN), .csOutN(csOutN), .mosiOut(mosiOut), .mosiIn(mosiIn),
    .misoOut(misoOut), .misoOe(misoOe), .misoIn(misoIn));
  spims_far_end #(.WIDTH(8)) spims_far_end_inst (.clock(clock), .sclk(sclkOut),
    .csN(csOutN), .cpha(cpha), .dIn(mosiOut), .reply(reply), .dOut(misoIn), .got(got));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, `SPIMS_OFF_CTRL, 32'h0);
    `CHK(rd, {16'h0, `SPIMS_DIV_RESET, 8'h00})
    apb(1'b0, `SPIMS_OFF_TIMING, 32'h0);
    `CHK(rd, {16'h0, `SPIMS_FWD_RESET, `SPIMS_CSD_RESET})
    apb(1'b0, `SPIMS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      cpha  <= i[1];
      reply <= 8'hA5 ^ 8'(i * 17);
      tx = 8'h3C ^ 8'(i * 33);
      apb(1'b1, `SPIMS_OFF_TIMING, {16'h0, 8'(3 * i), 8'(2 * i)});
      apb(1'b1, `SPIMS_OFF_CTRL, {16'h0, 8'h08, 4'h0, i[1], i[0], 2'h3});
      apb(1'b1, `SPIMS_OFF_TXDATA, {24'h0, tx});
      n = 0;
      while (csOutN !== 1'b0 && n < 200) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      tg = 0;
      lat = 0;
      prev = sclkOut;
      while (csOutN === 1'b0 && n < 2000) begin
        @(negedge clock);
        n++;
        if (sclkOut !== prev) begin
          tg++;
          if (tg == 1) lat = n;
        end
        prev = sclkOut;
      end
      // with cpha set the far end takes its last bit one clock after the final edge
      repeat (2) @(negedge clock);
      // a select delay of zero acts as one
      eff = (i == 0 ? 1 : 2 * i) + 3 * i;
      if (i == 0) base = lat - eff;
      `CHK(lat - eff, base)
      `CHK(tg, 16)
      `CHK(sclkOut, i[0])
      `CHK(got, tx)
      apb(1'b0, `SPIMS_OFF_RXDATA, 32'h0);
      `CHK(rd, {24'h0, reply})
    end
    $display("test master modes done");
    apb(1'b1, `SPIMS_OFF_STATUS, 32'h0000_0008);
    apb(1'b1, `SPIMS_OFF_CTRL, 32'h0000_0101);
    apb(1'b1, `SPIMS_OFF_TXDATA, 32'h0000_005A);
    @(posedge clock);
    csInN  <= 1'b0;
    mosiIn <= MOSI_WORD[15];
    repeat (4) @(posedge clock);
    // two words in one frame: the second follows with no gap
    for (int b = 15; b >= 0; b--) begin
      repeat (3) @(posedge clock);
      @(negedge clock);
      sg[b] = misoOut;
      if (b == 8) `CHK(misoOe, 1'b1)
      @(posedge clock);
      sclkIn <= 1'b1;
      repeat (4) @(posedge clock);
      sclkIn <= 1'b0;
      mosiIn <= (b > 0) ? MOSI_WORD[(b > 0 ? b - 1 : 0)] : ~MOSI_WORD[0];
    end
    repeat (4) @(posedge clock);
    csInN <= 1'b1;
    `CHK(sg, 16'h5A00)
    apb(1'b0, `SPIMS_OFF_STATUS, 32'h0);
    `CHK(rd & 32'h0000_000E, 32'h0000_000E)
    apb(1'b0, `SPIMS_OFF_RXDATA, 32'h0);
    `CHK(rd, {24'h0, MOSI_WORD[7:0]})
    $display("test slave frame done");
    tally_and_finish;
  end
endmodule

bind spims_top spims_assertions #(.WIDTH(WIDTH)) spims_assertions_inst (.clock(clock),
  .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sclkOut(sclkOut), .sclkOe(sclkOe),
  .csOutN(csOutN), .csInN(csInN), .misoOe(misoOe));
`default_nettype wire
